/* core/mad_motion_alarm_detector.sv */
// alarm detection, classification and lamp logic for a stepping driver
//
// Notes on behaviour
// - homing without sensor_input_a or timing raises 64h
// - enabled hardware overtravel on limit raises 66h
// - after clearing, moves away from limit allowed
// - enabled software overtravel at soft limit raises 67h
// - limit during homing offset raises 6Ah
// - linked data with mixed directions raises 70h
// - five or more linked entries raises 70h
// - positioning start at zero speed raises 70h
// - push start above 500 r/min raises 70h
// - resolution outside 100..10000 raises 71h
// - wrap range inconsistent with resolution raises 72h
// - gear and wrap alarms: no clear, excitation off
// - 64h to 70h clearable, excitation kept
// - bus disconnected while running raises 81h
// - excitation-off alarms cut current, apply brake
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "mad_defs.svh"

module mad_motion_alarm_detector #(
  parameter int unsigned BLINK_CYC = `MAD_BLINK_CYC,
  parameter int unsigned GAP_CYC   = `MAD_GAP_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // pins from sensors and the host
  input  wire logic        alarm_clear_input,
  input  wire logic        forward_limit_sensor,
  input  wire logic        reverse_limit_sensor,
  input  wire logic        home_sensor_input,
  input  wire logic        sensor_input_a,
  input  wire logic        net_host_disconnected,
  // same-domain motion controller status
  input  wire logic        step_timing_output,
  input  wire logic        homing_active,
  input  wire logic        homing_offset_phase,
  input  wire logic        homing_done,
  input  wire logic        motor_operating,
  input  wire logic        move_dir_forward,
  input  wire logic        continuous_active,
  input  wire logic        soft_limit_hit,
  input  wire logic        op_start,
  input  wire logic        op_is_push,
  input  wire logic        op_is_positioning,
  input  wire logic [15:0] op_speed,
  input  wire logic [3:0]  link_count,
  input  wire logic        link_dir_mixed,
  // configuration
  input  wire logic        sensor_input_a_check_en,
  input  wire logic        timing_check_en,
  input  wire logic        hw_overtravel_en,
  input  wire logic        sw_overtravel_en,
  input  wire logic [15:0] gear_resolution,
  input  wire logic        wrap_range_bad,
  // software register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // results
  output logic      [7:0]  alarm_code,
  output logic             alarm_active,
  output logic             excitation_off,
  output logic             brake_engage,
  output logic             motion_inhibit,
  output logic             alarm_indicator_lamp,
  output logic             irq
);

  // ****************************************
  // register offsets (word index)
  // ****************************************
  localparam logic [3:0] ADDR_CODE   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_MASK   = 4'h2;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [5:0] pin_s1_reg;
  logic [5:0] pin_s2_reg;
  logic       clr_q_reg;

  // two stages for every asynchronous pin
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_s1_reg <= 6'h00;
      pin_s2_reg <= 6'h00;
    end else if (clk_en) begin
      pin_s1_reg <= {alarm_clear_input, forward_limit_sensor,
                     reverse_limit_sensor, home_sensor_input,
                     sensor_input_a, net_host_disconnected};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  logic clr_s, fls_s, rls_s, home_s, sensor_input_a_s, netdis_s;
  assign {clr_s, fls_s, rls_s, home_s, sensor_input_a_s, netdis_s} = pin_s2_reg;

  // clear acts on the rising edge of the pin only
  always_ff @(posedge clk) begin
    if (reset) begin
      clr_q_reg <= 1'b0;
    end else if (clk_en) begin
      clr_q_reg <= clr_s;
    end
  end

  logic clear_pulse;
  assign clear_pulse = clr_s & ~clr_q_reg;

  // ****************************************
  // homing signal watch
  // ****************************************
  logic seen_sig_reg;

  // remember a sensor_input_a or timing hit while home sensor is on
  always_ff @(posedge clk) begin
    if (reset) begin
      seen_sig_reg <= 1'b0;
    end else if (clk_en) begin
      if (!homing_active) begin
        seen_sig_reg <= 1'b0;
      end else if (home_s && ((sensor_input_a_check_en && sensor_input_a_s) ||
                   (timing_check_en && step_timing_output))) begin
        seen_sig_reg <= 1'b1;
      end
    end
  end

  // ****************************************
  // fault detection
  // ****************************************
  function automatic logic res_bad(input logic [15:0] r);
    res_bad = (r < `MAD_RES_MIN) || (r > `MAD_RES_MAX);
  endfunction

  logic f_homesig, f_hwot, f_swot, f_offset, f_opdata;
  logic f_gear, f_wrap, f_net, checks_on;
  logic escape_ok, escape_reg, lim_dir_fwd_reg, fatal_reg;
  logic [7:0] code_reg;
  logic [7:0] code_next;

  // both checks disabled means homing needs neither signal
  assign checks_on = sensor_input_a_check_en | timing_check_en;
  assign f_homesig = homing_done & checks_on & ~seen_sig_reg;
  // limits during the offset phase belong to 6Ah instead
  assign f_hwot    = hw_overtravel_en & (fls_s | rls_s)
                     & ~homing_offset_phase & ~escape_ok;
  assign f_swot    = sw_overtravel_en & soft_limit_hit;
  assign f_offset  = homing_active & homing_offset_phase
                     & (fls_s | rls_s);
  assign f_opdata  = op_start & (link_dir_mixed
                     | (link_count > `MAD_LINK_MAX)
                     | (op_is_positioning
                        & (op_speed == `MAD_SPEED_MIN))
                     | (op_is_push
                        & (op_speed > `MAD_PUSH_SPEED_MAX)));
  assign f_gear    = res_bad(gear_resolution);
  assign f_wrap    = wrap_range_bad;
  assign f_net     = motor_operating & netdis_s;

  // ****************************************
  // escape from a limit after a clear
  // ****************************************
  // moving away by continuous run or homing is not a new overtravel
  always_ff @(posedge clk) begin
    if (reset) begin
      escape_reg      <= 1'b0;
      lim_dir_fwd_reg <= 1'b0;
    end else if (clk_en) begin
      if (f_hwot && !alarm_active) begin
        lim_dir_fwd_reg <= fls_s;
      end
      if (clear_pulse && code_reg == `MAD_CODE_HW_OT) begin
        escape_reg <= 1'b1;
      end else if (!(fls_s | rls_s)) begin
        escape_reg <= 1'b0;
      end
    end
  end

  assign escape_ok = escape_reg & (homing_active | (continuous_active
                     & (move_dir_forward != lim_dir_fwd_reg)));

  // ****************************************
  // alarm latch
  // ****************************************
  // one fault is latched; fatal faults first, then by code
  always_comb begin
    code_next = `MAD_CODE_NONE;
    if (f_gear) begin
      code_next = `MAD_CODE_GEAR;
    end else if (f_wrap) begin
      code_next = `MAD_CODE_WRAP;
    end else if (f_homesig) begin
      code_next = `MAD_CODE_HOMESIG;
    end else if (f_hwot) begin
      code_next = `MAD_CODE_HW_OT;
    end else if (f_swot) begin
      code_next = `MAD_CODE_SW_OT;
    end else if (f_offset) begin
      code_next = `MAD_CODE_OFFSET;
    end else if (f_opdata) begin
      code_next = `MAD_CODE_OPDATA;
    end else if (f_net) begin
      code_next = `MAD_CODE_NETBUS;
    end
  end

  // fatal alarms ignore the clear pin; only reset (power) frees them
  always_ff @(posedge clk) begin
    if (reset) begin
      code_reg  <= `MAD_CODE_NONE;
      fatal_reg <= 1'b0;
    end else if (clk_en) begin
      if (fatal_reg) begin
        code_reg <= code_reg;
      end else if (code_next == `MAD_CODE_GEAR ||
                   code_next == `MAD_CODE_WRAP) begin
        code_reg  <= code_next;
        fatal_reg <= 1'b1;
      end else if (code_reg != `MAD_CODE_NONE) begin
        if (clear_pulse) begin
          code_reg <= `MAD_CODE_NONE;
        end
      end else begin
        code_reg <= code_next;
      end
    end
  end

  assign alarm_code     = code_reg;
  assign alarm_active   = (code_reg != `MAD_CODE_NONE);
  assign excitation_off = fatal_reg;
  assign brake_engage   = fatal_reg;
  assign motion_inhibit = alarm_active;

  // ****************************************
  // lamp blink sequencer
  // ****************************************
  mad_pkg::mad_lamp_state_t lamp_state_reg;
  logic [31:0] lamp_tmr_reg;
  logic [3:0]  blink_left_reg;
  logic [3:0]  blinks;

  // blink count by alarm group
  always_comb begin
    blinks = `MAD_BLINK_NONE;
    if (code_reg == `MAD_CODE_OPDATA || fatal_reg) begin
      blinks = `MAD_BLINK_DATA;
    end else if (alarm_active) begin
      blinks = `MAD_BLINK_MOTION; // bus loss joins this group
    end
  end

  // bursts of blinks separated by a long gap
  always_ff @(posedge clk) begin
    if (reset) begin
      lamp_state_reg <= mad_pkg::MAD_LAMP_IDLE;
      lamp_tmr_reg   <= 32'h0000_0000;
      blink_left_reg <= 4'h0;
    end else if (clk_en) begin
      unique case (lamp_state_reg)
        mad_pkg::MAD_LAMP_IDLE: begin
          if (blinks == `MAD_BLINK_NONE) begin
            lamp_tmr_reg <= 32'h0000_0000;
          end else if (lamp_tmr_reg == 32'h0000_0000) begin
            lamp_state_reg <= mad_pkg::MAD_LAMP_ON;
            blink_left_reg <= blinks;
            lamp_tmr_reg   <= BLINK_CYC - 1;
          end else begin
            lamp_tmr_reg <= lamp_tmr_reg - 32'h0000_0001;
          end
        end
        mad_pkg::MAD_LAMP_ON: begin
          if (lamp_tmr_reg == 32'h0000_0000) begin
            lamp_state_reg <= mad_pkg::MAD_LAMP_OFF;
            blink_left_reg <= blink_left_reg - 4'h1;
            lamp_tmr_reg   <= BLINK_CYC - 1;
          end else begin
            lamp_tmr_reg <= lamp_tmr_reg - 32'h0000_0001;
          end
        end
        mad_pkg::MAD_LAMP_OFF: begin
          if (blinks == `MAD_BLINK_NONE) begin
            lamp_state_reg <= mad_pkg::MAD_LAMP_IDLE;
            lamp_tmr_reg   <= 32'h0000_0000;
          end else if (lamp_tmr_reg != 32'h0000_0000) begin
            lamp_tmr_reg <= lamp_tmr_reg - 32'h0000_0001;
          end else if (blink_left_reg == 4'h0) begin
            lamp_state_reg <= mad_pkg::MAD_LAMP_IDLE;
            lamp_tmr_reg   <= GAP_CYC - 1;
          end else begin
            lamp_state_reg <= mad_pkg::MAD_LAMP_ON;
            lamp_tmr_reg   <= BLINK_CYC - 1;
          end
        end
        default: begin
          lamp_state_reg <= mad_pkg::MAD_LAMP_IDLE;
        end
      endcase
    end
  end

  assign alarm_indicator_lamp = (lamp_state_reg == mad_pkg::MAD_LAMP_ON);

  // ****************************************
  // interrupt status and mask
  // ****************************************
  logic [7:0] status_reg;
  logic [7:0] mask_reg;
  logic [7:0] events;

  // one bit per fault kind
  assign events = {f_net, f_wrap, f_gear, f_opdata,
                   f_offset, f_swot, f_hwot, f_homesig};

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      status_reg <= 8'h00;
    end else if (clk_en) begin
      if (reg_wr && reg_addr == ADDR_STATUS) begin
        status_reg <= (status_reg & ~reg_wdata[7:0]) | events;
      end else begin
        status_reg <= status_reg | events;
      end
    end
  end

  // mask register
  always_ff @(posedge clk) begin
    if (reset) begin
      mask_reg <= 8'h00;
    end else if (clk_en && reg_wr && reg_addr == ADDR_MASK) begin
      mask_reg <= reg_wdata[7:0];
    end
  end

  assign irq = |(status_reg & mask_reg);

  // read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else if (clk_en) begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        unique case (reg_addr)
          ADDR_CODE:   reg_rdata <= {22'h0, fatal_reg,
                                     alarm_active, code_reg};
          ADDR_STATUS: reg_rdata <= {24'h000000, status_reg};
          ADDR_MASK:   reg_rdata <= {24'h000000, mask_reg};
          default:     reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // mad_motion_alarm_detector

/* pkg/mad_defs.svh */
// alarm codes, classes and limits for the motion alarm detector
`ifndef MAD_DEFS_SVH
`define MAD_DEFS_SVH

// ****************************************
// alarm codes
// ****************************************
`define MAD_CODE_NONE     8'h00
`define MAD_CODE_HOMESIG  8'h64
`define MAD_CODE_HW_OT    8'h66
`define MAD_CODE_SW_OT    8'h67
`define MAD_CODE_OFFSET   8'h6A
`define MAD_CODE_OPDATA   8'h70
`define MAD_CODE_GEAR     8'h71
`define MAD_CODE_WRAP     8'h72
`define MAD_CODE_NETBUS   8'h81

// ****************************************
// lamp blink counts and limits
// ****************************************
`define MAD_BLINK_MOTION  4'h7
`define MAD_BLINK_DATA    4'h1
`define MAD_BLINK_NONE    4'h0
`define MAD_LINK_MAX      4'h4
`define MAD_SPEED_MIN     16'h0000
`define MAD_PUSH_SPEED_MAX 16'h01F4
`define MAD_RES_MIN       16'h0064
`define MAD_RES_MAX       16'h2710

// ****************************************
// lamp timing: 200 ms on/off, 1 s gap
// ****************************************
`define MAD_BLINK_MS      200
`define MAD_GAP_MS        1000
`define MAD_CLK_KHZ       10000
`define MAD_BLINK_CYC     (`MAD_BLINK_MS * `MAD_CLK_KHZ)
`define MAD_GAP_CYC       (`MAD_GAP_MS * `MAD_CLK_KHZ)

`endif

/* pkg/mad_pkg.sv */
// types for the motion alarm detector
package mad_pkg;

  // ****************************************
  // lamp sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    MAD_LAMP_IDLE = 3'b001,
    MAD_LAMP_ON   = 3'b010,
    MAD_LAMP_OFF  = 3'b100
  } mad_lamp_state_t;

endpackage

/* sim/mad_alarm_chk.sv */
// port checker for the motion alarm detector
`timescale 1ns/1ps
module mad_alarm_chk #(
  parameter int unsigned BLINK_CYC = 4,
  parameter int unsigned GAP_CYC   = 8
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        alarm_clear_input,
  input wire logic        forward_limit_sensor,
  input wire logic        reverse_limit_sensor,
  input wire logic        continuous_active,
  input wire logic        homing_active,
  input wire logic        hw_overtravel_en,
  input wire logic        sw_overtravel_en,
  input wire logic        soft_limit_hit,
  input wire logic        reg_rd,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_rdata,
  input wire logic [7:0]  alarm_code,
  input wire logic        alarm_active,
  input wire logic        excitation_off,
  input wire logic        brake_engage,
  input wire logic        motion_inhibit
);
  // ****************************************
  // alarm relations
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // pins lag two sync stages, so four cycles of limit must trip
  hw_trip_a: assert property (
    (hw_overtravel_en && (forward_limit_sensor || reverse_limit_sensor) &&
     !continuous_active && !homing_active && !alarm_clear_input)[*4]
    |-> alarm_active)
    else $error("limit held but no alarm");
  sw_trip_a: assert property (
    (sw_overtravel_en && soft_limit_hit && !alarm_clear_input)[*4]
    |-> alarm_active)
    else $error("soft limit held but no alarm");
  fatal_exc_a: assert property (
    alarm_code inside {8'h71, 8'h72} |-> excitation_off && brake_engage)
    else $error("fatal code without excitation off");
  keep_exc_a: assert property (
    alarm_active && !(alarm_code inside {8'h71, 8'h72})
    |-> !excitation_off && !brake_engage)
    else $error("resettable code dropped excitation");
  fatal_hold_a: assert property (
    excitation_off |=> excitation_off && alarm_active)
    else $error("fatal alarm left without reset");
  // no clear edge can be pending after four low cycles of the pin
  code_hold_a: assert property (
    (alarm_active && !alarm_clear_input)[*4]
    |=> $stable(alarm_code) || alarm_code inside {8'h71, 8'h72})
    else $error("latched code changed without clear");
  inhibit_a: assert property (
    motion_inhibit == alarm_active && alarm_active == (alarm_code != 8'h00))
    else $error("inhibit, active and code disagree");
  rd_code_a: assert property (
    reg_rd && reg_addr == 4'h0 |=> reg_rdata ==
    {22'h0, $past(excitation_off), $past(alarm_active), $past(alarm_code)})
    else $error("code read returned wrong word");
  rd_idle_a: assert property (
    !reg_rd |=> reg_rdata == 32'h0)
    else $error("read data not zero outside read");
endmodule // mad_alarm_chk

bind mad_motion_alarm_detector mad_alarm_chk #(
  .BLINK_CYC(BLINK_CYC),
  .GAP_CYC  (GAP_CYC)
) u_mad_alarm_chk (
  .clk, .reset, .alarm_clear_input, .forward_limit_sensor,
  .reverse_limit_sensor, .continuous_active, .homing_active,
  .hw_overtravel_en, .sw_overtravel_en, .soft_limit_hit, .reg_rd,
  .reg_addr, .reg_rdata, .alarm_code, .alarm_active, .excitation_off,
  .brake_engage, .motion_inhibit
);

/* sim/mad_field_model.sv */
// home and sensor_input_a sensor model seen during homing
`timescale 1ns/1ps
module mad_field_model (
  input  wire logic clk,
  input  wire logic homing_active,
  input  wire logic sensor_input_a_fitted,
  output logic      home_sensor_input,
  output logic      sensor_input_a
);
  // sensors idle low until the first edge
  initial begin
    home_sensor_input = 1'h0;
    sensor_input_a    = 1'h0;
  end
  // home dog a cycle into homing; sensor_input_a only when fitted
  always @(posedge clk) begin
    home_sensor_input <= homing_active;
    sensor_input_a    <= homing_active && sensor_input_a_fitted;
  end
endmodule // mad_field_model

/* sim/mad_motion_alarm_detector_tb_top.sv */
// self-checking bench for the motion alarm detector
`timescale 1ns/1ps
module mad_motion_alarm_detector_tb_top;
  typedef struct {int k; logic [7:0] code; logic fat; logic b7;} mad_row_t;
  logic        clk = 1'h0, reset = 1'h1, clk_en = 1'h1, sensor_input_a_fitted, prev;
  logic        alarm_clear_input, forward_limit_sensor, reverse_limit_sensor;
  logic        home_sensor_input, sensor_input_a, net_host_disconnected;
  logic        step_timing_output, homing_active, homing_offset_phase;
  logic        homing_done, motor_operating, move_dir_forward;
  logic        continuous_active, soft_limit_hit, op_start, op_is_push;
  logic        op_is_positioning, link_dir_mixed, sensor_input_a_check_en;
  logic        timing_check_en, hw_overtravel_en, sw_overtravel_en;
  logic        wrap_range_bad, reg_wr, reg_rd, alarm_active, irq;
  logic        excitation_off, brake_engage, motion_inhibit;
  logic        alarm_indicator_lamp;
  logic [15:0] op_speed, gear_resolution;
  logic [3:0]  link_count, reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  logic [7:0]  alarm_code;
  int          n_fail = 0, n_compared = 0, cycles = 0, rises;
  // fault kind, code, fatal, seven-blink group
  mad_row_t rows [22] = '{
    '{0, 8'h66, 1'h0, 1'h1}, '{1, 8'h66, 1'h0, 1'h1},
    '{2, 8'h67, 1'h0, 1'h1}, '{3, 8'h6A, 1'h0, 1'h1},
    '{4, 8'h70, 1'h0, 1'h0}, '{5, 8'h70, 1'h0, 1'h0},
    '{6, 8'h70, 1'h0, 1'h0}, '{7, 8'h70, 1'h0, 1'h0},
    '{8, 8'h81, 1'h0, 1'h1}, '{9, 8'h64, 1'h0, 1'h1},
    '{10, 8'h71, 1'h1, 1'h0}, '{11, 8'h71, 1'h1, 1'h0},
    '{12, 8'h72, 1'h1, 1'h0}, '{13, 8'h00, 1'h0, 1'h0},
    '{14, 8'h00, 1'h0, 1'h0}, '{15, 8'h00, 1'h0, 1'h0},
    '{16, 8'h00, 1'h0, 1'h0}, '{17, 8'h00, 1'h0, 1'h0},
    '{18, 8'h00, 1'h0, 1'h0}, '{19, 8'h00, 1'h0, 1'h0},
    '{20, 8'h00, 1'h0, 1'h0}, '{21, 8'h00, 1'h0, 1'h0}};

  mad_motion_alarm_detector #(.BLINK_CYC(4), .GAP_CYC(8))
    u_mad_motion_alarm_detector (.*);
  mad_field_model u_mad_field_model (.clk, .homing_active, .sensor_input_a_fitted,
    .home_sensor_input, .sensor_input_a);

  // ****************************************
  // clock, watchdog and shared tasks
  // ****************************************
  always #50 clk = ~clk;
  // ceiling well above the ~2000 cycles the sequence needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      n_fail++;
      conclude;
    end
  end
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // all stimulus but reset and clk_en to its quiet value; no clock wait inside
  task automatic idle;
    {forward_limit_sensor, reverse_limit_sensor, soft_limit_hit} <= 3'h0;
    {homing_active, homing_offset_phase, motor_operating} <= 3'h0;
    {net_host_disconnected, hw_overtravel_en, sw_overtravel_en} <= 3'h0;
    {wrap_range_bad, continuous_active, sensor_input_a_fitted} <= 3'h0;
    {op_start, op_is_push, op_is_positioning, link_dir_mixed} <= 4'h0;
    {homing_done, step_timing_output, alarm_clear_input} <= 3'h0;
    {move_dir_forward, reg_wr, reg_rd} <= 3'h0;
    {sensor_input_a_check_en, timing_check_en} <= 2'h3;
    {op_speed, link_count, reg_addr} <= 24'h0;
    reg_wdata <= 32'h0;
    gear_resolution <= 16'h03E8;
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, d};
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'h1, a};
    @(posedge clk);
    reg_rd <= 1'h0;
    #1 rd_val = reg_rdata;
  endtask
  task automatic reset_dut;
    @(posedge clk);
    idle;
    reset <= 1'h1;
    tick(10);
    reset <= 1'h0;
    tick(3);
    wr(4'h2, 32'h0000_00FF);
  endtask
  // clear pin held long enough to pass the two-stage sync
  task automatic clr;
    @(posedge clk);
    alarm_clear_input <= 1'h1;
    tick(4);
    alarm_clear_input <= 1'h0;
    tick(4);
  endtask
  task automatic op(logic p, logic [15:0] s, logic [3:0] n, logic m);
    @(posedge clk);
    {op_start, op_is_push, op_is_positioning} <= {1'h1, p, !p};
    {op_speed, link_count, link_dir_mixed} <= {s, n, m};
    @(posedge clk);
    op_start <= 1'h0;
  endtask
  task automatic home(logic se, logic te, logic sf, logic tm);
    @(posedge clk);
    {sensor_input_a_check_en, timing_check_en, sensor_input_a_fitted} <= {se, te, sf};
    {homing_active, step_timing_output} <= {1'h1, tm};
    tick(6);
    homing_done <= 1'h1;
    @(posedge clk);
    {homing_done, homing_active, step_timing_output} <= 3'h0;
  endtask
  task automatic apply(int k);
    @(posedge clk);
    case (k)
      0, 19: {hw_overtravel_en, forward_limit_sensor} <= {k == 0, 1'h1};
      1: {hw_overtravel_en, reverse_limit_sensor} <= 2'h3;
      2: {sw_overtravel_en, soft_limit_hit} <= 2'h3;
      3: {homing_active, homing_offset_phase, forward_limit_sensor} <= 3'h7;
      4: op(1'h0, 16'h0064, 4'h2, 1'h1);
      5: op(1'h0, 16'h0064, 4'h5, 1'h0);
      6: op(1'h0, 16'h0000, 4'h1, 1'h0);
      7: op(1'h1, 16'h01F5, 4'h1, 1'h0);
      8, 20: {motor_operating, net_host_disconnected} <= {k == 8, 1'h1};
      9: home(1'h1, 1'h1, 1'h0, 1'h0);
      10: gear_resolution <= 16'h0063;
      11: gear_resolution <= 16'h2711;
      12: wrap_range_bad <= 1'h1;
      13: op(1'h1, 16'h01F4, 4'h1, 1'h0);
      14: gear_resolution <= 16'h2710;
      15: gear_resolution <= 16'h0064;
      16: op(1'h0, 16'h0064, 4'h4, 1'h0);
      17: home(1'h0, 1'h1, 1'h0, 1'h1);
      18: home(1'h0, 1'h0, 1'h0, 1'h0);
      21: home(1'h1, 1'h0, 1'h1, 1'h0);
      default: ;
    endcase
  endtask
  task automatic conclude;
    if (n_fail == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    idle;
    reset_dut;
    foreach (rows[i]) begin
      apply(rows[i].k);
      tick(5);
      #1 chk("code", alarm_code, rows[i].code);
      chk("exc_off", excitation_off, rows[i].fat);
      chk("brake", brake_engage, rows[i].fat);
      chk("irq", irq, rows[i].code != 8'h00);
      rises = 0;
      repeat (64) begin
        prev = alarm_indicator_lamp;
        @(posedge clk);
        #1 rises += int'(alarm_indicator_lamp && !prev);
      end
      if (rows[i].code != 8'h00)
        chk("lamp7", rises > 5, rows[i].b7);
      @(posedge clk);
      idle;
      clr;
      #1 chk("clr", alarm_code, rows[i].fat ? rows[i].code : 8'h0);
      if (rows[i].fat)
        reset_dut;
      wr(4'h1, 32'h0000_00FF);
      tick(1);
      #1 chk("irq_clr", irq, 1'h0);
    end
    // latched overtravel refuses a soft limit; gear error overrides
    @(posedge clk);
    {hw_overtravel_en, forward_limit_sensor} <= 2'h3;
    tick(5);
    {sw_overtravel_en, soft_limit_hit} <= 2'h3;
    tick(3);
    rd(4'h0);
    chk("rd_code", rd_val, 32'h0000_0166);
    rd(4'h1);
    chk("rd_stat", rd_val[1:0], 2'h2);
    rd(4'h5);
    chk("rd_unmapped", rd_val, 32'h0);
    wr(4'h2, 32'h0);
    wr(4'h5, 32'hFFFF_FFFF);
    tick(1);
    #1 chk("irq_masked", irq, 1'h0);
    rd(4'h2);
    chk("mask", rd_val, 32'h0);
    @(posedge clk);
    gear_resolution <= 16'h0063;
    tick(4);
    clr;
    #1 chk("override", alarm_code, 8'h71);
    rd(4'h0);
    chk("rd_fatal", rd_val, 32'h0000_0371);
    reset_dut;
    #1 chk("rst_out", {alarm_code, alarm_active, excitation_off, irq,
      brake_engage, motion_inhibit, alarm_indicator_lamp}, 32'h0);
    // escape from a limit by continuous move after clearing
    @(posedge clk);
    {hw_overtravel_en, reverse_limit_sensor} <= 2'h3;
    tick(5);
    {continuous_active, move_dir_forward} <= 2'h3;
    clr;
    #1 chk("escape", alarm_code, 8'h00);
    // a frozen clock enable keeps the latch through a clear press
    @(posedge clk);
    idle;
    {sw_overtravel_en, soft_limit_hit} <= 2'h3;
    tick(2);
    {sw_overtravel_en, soft_limit_hit, clk_en} <= 3'h0;
    clr;
    #1 chk("frozen", alarm_code, 8'h67);
    @(posedge clk);
    clk_en <= 1'h1;
    tick(2);
    conclude;
  end
endmodule // mad_motion_alarm_detector_tb_top
